// file: rtl/psa_lane_adder.sv
// Packed SIMD lane adder with shared register file and short-vector sequencer
`default_nettype none
module psa_lane_adder #(
  parameter bit HAS_FPU = 1'b1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Packed operation issue
  input wire logic opValid,
  input wire logic opWide,
  input wire psa_pkg::psa_elem_t opElem,
  input wire logic [psa_pkg::D_IDX_W-1:0] opDst,
  input wire logic [psa_pkg::D_IDX_W-1:0] opSrcA,
  input wire logic [psa_pkg::D_IDX_W-1:0] opSrcB,
  // Short-vector float add issue, length code is run length minus one
  input wire logic vecValid,
  input wire logic [psa_pkg::LEN_W-1:0] vectorLengthSetting,
  input wire logic [psa_pkg::S_IDX_W-1:0] vecDst,
  input wire logic [psa_pkg::S_IDX_W-1:0] vecSrcA,
  input wire logic [psa_pkg::S_IDX_W-1:0] vecSrcB,
  // Scalar floating-point unit access to the shared file
  input wire logic fpuWrEn,
  input wire logic [psa_pkg::D_IDX_W-1:0] fpuWrIdx,
  input wire logic [psa_pkg::D_W-1:0] fpuWrData,
  input wire logic [psa_pkg::D_IDX_W-1:0] fpuRdIdx,
  output logic [psa_pkg::D_W-1:0] fpuRdData,
  // Status
  output logic busy,
  output logic done,
  output logic undefOp
);
  import psa_pkg::*;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  // Truncating single-precision add; denormals flush to zero, a larger operand with exponent 255 (NaN or infinity) is returned unchanged
  function automatic logic [31:0] fpAdd(input logic [31:0] x, input logic [31:0] y);
    logic [31:0] a;
    logic [31:0] b;
    logic [7:0] e;
    logic [7:0] d;
    logic [24:0] ma;
    logic [24:0] mb;
    logic [24:0] s;
    logic [31:0] r;
    if (x[30:0] < y[30:0]) begin
      a = y;
      b = x;
    end else begin
      a = x;
      b = y;
    end
    e = a[30:23];
    d = 8'(a[30:23] - b[30:23]);
    ma = {2'b01, a[22:0]};
    mb = (b[30:23] == 8'h00 || d > 8'h18) ? 25'h000_0000 : ({2'b01, b[22:0]} >> d);
    s = (a[31] == b[31]) ? 25'(ma + mb) : 25'(ma - mb);
    r = {a[31], 31'h0000_0000};
    if (e == 8'h00) begin
      r = 32'h0000_0000;
    end else if (e == 8'hff) begin
      r = a;
    end else if (s == 25'h000_0000) begin
      r = 32'h0000_0000;
    end else if (s[24]) begin
      s = s >> 1;
      e = 8'(e + 8'h01);
      r = (e == 8'hff) ? {a[31], 8'hff, 23'h00_0000} : {a[31], e, s[22:0]};
    end else begin
      for (int i = 0; i < 24; i++) begin
        if (!s[23] && e != 8'h00) begin
          s = s << 1;
          e = 8'(e - 8'h01);
        end
      end
      r = (e == 8'h00) ? 32'h0000_0000 : {a[31], e, s[22:0]};
    end
    return r;
  endfunction

  // Shared storage: 64-bit entries, pairs form the 128-bit view
  logic [D_W-1:0] rf_r [D_COUNT];
  logic [D_W-1:0] rf_nxt [D_COUNT];
  psa_state_t state_r, state_nxt;
  logic [LEN_W-1:0] vecLen_r, vecLen_nxt, vecCnt_r, vecCnt_nxt;
  logic [S_IDX_W-1:0] vecD_r, vecD_nxt, vecA_r, vecA_nxt, vecB_r, vecB_nxt;
  logic [D_W-1:0] fpuRdData_r, fpuRdData_nxt;
  logic done_r, done_nxt, undef_r, undef_nxt;

  // Operand fetch: the 128-bit view joins entries 2q and 2q+1
  logic [Q_W-1:0] aOp, bOp, pkRes, intRes, fltRes;
  logic [Q_IDX_W-1:0] qA, qB, qD;
  assign qA = opSrcA[Q_IDX_W-1:0];
  assign qB = opSrcB[Q_IDX_W-1:0];
  assign qD = opDst[Q_IDX_W-1:0];
  assign aOp = opWide ? {rf_r[{qA, 1'b1}], rf_r[{qA, 1'b0}]} : {64'h0000_0000_0000_0000, rf_r[opSrcA]};
  assign bOp = opWide ? {rf_r[{qB, 1'b1}], rf_r[{qB, 1'b0}]} : {64'h0000_0000_0000_0000, rf_r[opSrcB]};

  // Byte slices; a carry links two bytes only inside one lane
  logic [BYTE_LANES:0] carry;
  assign carry[0] = 1'b0;
  for (genvar i = 0; i < BYTE_LANES; i++) begin : g_byte
    logic link;
    assign link = (opElem == ELEM_I16 && (i % 2) != 0) || (opElem == ELEM_I32 && (i % 4) != 0);
    assign {carry[i+1], intRes[8*i +: 8]} =
      9'({1'b0, aOp[8*i +: 8]} + {1'b0, bOp[8*i +: 8]} + {8'h00, link & carry[i]});
  end

  // Float lanes share the 32-bit lane boundaries
  for (genvar j = 0; j < F32_LANES; j++) begin : g_flt
    assign fltRes[32*j +: 32] = fpAdd(aOp[32*j +: 32], bOp[32*j +: 32]);
  end
  assign pkRes = (opElem == ELEM_F32) ? fltRes : intRes;

  // Short-vector step operands, indices wrap from S31, the top of entry 15, to S0, the bottom of entry 0
  logic [S_IDX_W-1:0] sA, sB, sD;
  logic [S_W-1:0] sOpA, sOpB, sRes;
  assign sA = 5'(vecA_r + {2'b00, vecCnt_r});
  assign sB = 5'(vecB_r + {2'b00, vecCnt_r});
  assign sD = 5'(vecD_r + {2'b00, vecCnt_r});
  assign sOpA = rf_r[{1'b0, sA[4:1]}][32*sA[0] +: 32];
  assign sOpB = rf_r[{1'b0, sB[4:1]}][32*sB[0] +: 32];
  assign sRes = fpAdd(sOpA, sOpB);

  // Issue decode; packed issue wins over a vector issue in the same cycle
  logic pkAccept, pkLegal, vecAccept, vecGo;
  assign pkAccept = opValid && state_r == VEC_IDLE;
  assign pkLegal = opElem != ELEM_F32 || HAS_FPU;
  assign vecAccept = vecValid && !opValid && state_r == VEC_IDLE;
  assign vecGo = vecAccept && HAS_FPU;

  // Next state of storage, sequencer and status
  always_comb begin
    rf_nxt = rf_r;
    state_nxt = state_r;
    vecLen_nxt = vecLen_r;
    vecCnt_nxt = vecCnt_r;
    vecD_nxt = vecD_r;
    vecA_nxt = vecA_r;
    vecB_nxt = vecB_r;
    done_nxt = 1'b0;
    undef_nxt = (pkAccept && !pkLegal) || (vecAccept && !HAS_FPU);
    fpuRdData_nxt = rf_r[fpuRdIdx];
    // Floating-point port writes first so datapath results win a clash
    if (fpuWrEn) begin
      rf_nxt[fpuWrIdx] = fpuWrData;
    end
    if (pkAccept && pkLegal) begin
      done_nxt = 1'b1;
      if (opWide) begin
        rf_nxt[{qD, 1'b0}] = pkRes[63:0];
        rf_nxt[{qD, 1'b1}] = pkRes[127:64];
      end else begin
        rf_nxt[opDst] = pkRes[63:0];
      end
    end
    case (state_r)
      VEC_IDLE: begin
        if (vecGo) begin
          state_nxt = VEC_RUN;
          vecLen_nxt = vectorLengthSetting;
          vecCnt_nxt = LEN_RST;
          vecD_nxt = vecDst;
          vecA_nxt = vecSrcA;
          vecB_nxt = vecSrcB;
        end
      end
      VEC_RUN: begin
        // One element per cycle keeps a single float adder
        rf_nxt[{1'b0, sD[4:1]}][32*sD[0] +: 32] = sRes;
        if (vecCnt_r == vecLen_r) begin
          state_nxt = VEC_IDLE;
          done_nxt = 1'b1;
        end else begin
          vecCnt_nxt = 3'(vecCnt_r + 3'h1);
        end
      end
      default: state_nxt = VEC_IDLE;
    endcase
  end

  // Registers of storage, sequencer and status
  always_ff @(posedge clock) begin
    if (!nrst) begin
      for (int k = 0; k < D_COUNT; k++) begin
        rf_r[k] <= RF_RST;
      end
      state_r <= VEC_IDLE;
      vecLen_r <= LEN_RST;
      vecCnt_r <= LEN_RST;
      vecD_r <= '0;
      vecA_r <= '0;
      vecB_r <= '0;
      fpuRdData_r <= RF_RST;
      done_r <= 1'b0;
      undef_r <= 1'b0;
    end else begin
      rf_r <= rf_nxt;
      state_r <= state_nxt;
      vecLen_r <= vecLen_nxt;
      vecCnt_r <= vecCnt_nxt;
      vecD_r <= vecD_nxt;
      vecA_r <= vecA_nxt;
      vecB_r <= vecB_nxt;
      fpuRdData_r <= fpuRdData_nxt;
      done_r <= done_nxt;
      undef_r <= undef_nxt;
    end
  end

  assign fpuRdData = fpuRdData_r;
  assign busy = state_r == VEC_RUN;
  assign done = done_r;
  assign undefOp = undef_r;

  // Expected lane sums for the checks below
  logic [7:0] expB1, expB15;
  logic [15:0] expH1;
  logic [31:0] expW0;
  logic intGo, vecGoLen4;
  assign expB1 = 8'(aOp[15:8] + bOp[15:8]);
  assign expB15 = 8'(aOp[127:120] + bOp[127:120]);
  assign expH1 = 16'(aOp[31:16] + bOp[31:16]);
  assign expW0 = 32'(aOp[31:0] + bOp[31:0]);
  assign intGo = pkAccept && opElem != ELEM_F32 && !fpuWrEn;
  assign vecGoLen4 = vecGo && vectorLengthSetting == 3'h3;

  byteLane_iso_a: assert property (intGo && !opWide && opElem == ELEM_I8 |=>
    rf_r[$past(opDst)][15:8] == $past(expB1)) else $error("byte lane took a carry");
  halfLane_wrap_a: assert property (intGo && !opWide && opElem == ELEM_I16 |=>
    rf_r[$past(opDst)][31:16] == $past(expH1)) else $error("half lane sum wrong");
  wordLane_sum_a: assert property (intGo && !opWide && opElem == ELEM_I32 |=>
    rf_r[$past(opDst)][31:0] == $past(expW0)) else $error("word lane sum wrong");
  wideTop_lane_a: assert property (intGo && opWide && opElem == ELEM_I8 |=>
    rf_r[{$past(qD), 1'b1}][63:56] == $past(expB15)) else $error("top wide lane wrong");
  // A back-to-back packed op may legally hold done high a second cycle
  packedOne_cycle_a: assert property (pkAccept && pkLegal |=> done && !busy ##1
    (!done || $past(opValid))) else $error("packed op did not finish in one cycle");
  vecFour_steps_a: assert property (vecGoLen4 |=> busy [*4] ##1 (!busy && done))
    else $error("length four did not take four steps");
  vecScalar_a: assert property (vecGo && vectorLengthSetting == 3'h0 |=> busy ##1
    (!busy && done)) else $error("scalar op not single step");
  vecStep_wr_a: assert property (busy |=>
    rf_r[{1'b0, $past(sD[4:1])}][32*$past(sD[0]) +: 32] == $past(sRes))
    else $error("vector step result lost");
  fltGate_a: assert property (pkAccept && opElem == ELEM_F32 |=> undefOp == !HAS_FPU
    && done == HAS_FPU) else $error("float gating wrong");
  fpuShare_a: assert property (fpuWrEn && !pkAccept && !busy ##1
    (fpuRdIdx == $past(fpuWrIdx) && !fpuWrEn && !pkAccept && !busy) |=>
    fpuRdData == $past(fpuWrData, 2)) else $error("shared storage mismatch");

  wideAdd_c: cover property (pkAccept && opWide && opElem == ELEM_I8);
  vecRun8_c: cover property (vecGo && vectorLengthSetting == 3'h7);
  fltPacked_c: cover property (pkAccept && opElem == ELEM_F32 && pkLegal);
  carryCut_c: cover property (intGo && opElem == ELEM_I8 && carry[1]);
endmodule
`default_nettype wire

// file: rtl/psa_pkg.sv
// Package of constants and types for the packed lane adder
`default_nettype none
package psa_pkg;
  // Register file geometry
  localparam int unsigned D_COUNT = 32;
  localparam int unsigned D_W = 64;
  localparam int unsigned Q_W = 128;
  localparam int unsigned D_IDX_W = 5;
  localparam int unsigned Q_IDX_W = 4;
  localparam int unsigned S_IDX_W = 5;
  localparam int unsigned S_W = 32;
  localparam int unsigned BYTE_LANES = 16;
  localparam int unsigned F32_LANES = 4;
  localparam int unsigned LEN_W = 3;
  // Reset values
  localparam logic [63:0] RF_RST = 64'h0000_0000_0000_0000;
  localparam logic [2:0] LEN_RST = 3'h0;
  // Element-size codes of a packed operation
  typedef enum logic [1:0] {
    ELEM_I8 = 2'b00,
    ELEM_I16 = 2'b01,
    ELEM_I32 = 2'b10,
    ELEM_F32 = 2'b11
  } psa_elem_t;
  // Short-vector sequencer states
  typedef enum logic [0:0] {
    VEC_IDLE = 1'b0,
    VEC_RUN = 1'b1
  } psa_state_t;
endpackage
`default_nettype wire

// file: tb/psa_host_model.sv
// Host issue pipeline model that drives the lane adder's request ports
`default_nettype none
module psa_host_model (
  // Clock
  input wire logic clock,
  // Packed issue
  output logic opValid,
  output logic opWide,
  output psa_pkg::psa_elem_t opElem,
  output logic [4:0] opDst,
  output logic [4:0] opSrcA,
  output logic [4:0] opSrcB,
  // Vector issue
  output logic vecValid,
  output logic [2:0] vecLen,
  output logic [4:0] vecDst,
  output logic [4:0] vecSrcA,
  output logic [4:0] vecSrcB,
  // Shared file access
  output logic fpuWrEn,
  output logic [4:0] fpuWrIdx,
  output logic [63:0] fpuWrData,
  output logic [4:0] fpuRdIdx,
  input wire logic [63:0] fpuRdData
);
  timeunit 1ns;
  timeprecision 1ps;
  import psa_pkg::*;
  // Idle values from time zero so no request leaks out of reset
  initial begin
    {opValid, opWide, vecValid, fpuWrEn} = 4'h0;
    opElem = ELEM_I8;
    {opDst, opSrcA, opSrcB, vecDst, vecSrcA, vecSrcB, fpuWrIdx, fpuRdIdx} = 40'h0;
    {vecLen, fpuWrData} = 67'h0;
  end
  // One packed request, taken at the edge after it is raised
  task automatic packedAdd(input logic w, input psa_elem_t e, input logic [4:0] d, a, b);
    @(posedge clock);
    {opValid, opWide, opElem, opDst, opSrcA, opSrcB} <= {1'b1, w, e, d, a, b};
    @(posedge clock);
    opValid <= 1'b0;
  endtask
  // One short-vector request; the length code is run length minus one
  task automatic vector(input logic [2:0] l, input logic [4:0] d, a, b);
    @(posedge clock);
    {vecValid, vecLen, vecDst, vecSrcA, vecSrcB} <= {1'b1, l, d, a, b};
    @(posedge clock);
    vecValid <= 1'b0;
  endtask
  // Scalar unit write, one cycle
  task automatic write(input logic [4:0] i, input logic [63:0] v);
    @(posedge clock);
    {fpuWrEn, fpuWrIdx, fpuWrData} <= {1'b1, i, v};
    @(posedge clock);
    fpuWrEn <= 1'b0;
  endtask
  // Read is registered, so data is taken one edge after the index settles
  task automatic read(input logic [4:0] i, output logic [63:0] v);
    @(posedge clock);
    fpuRdIdx <= i;
    @(posedge clock);
    #1 v = fpuRdData;
  endtask
endmodule
`default_nettype wire

// file: tb/psa_lane_adder_tb.sv
// Self-checking bench for the packed lane adder
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module psa_lane_adder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import psa_pkg::*;
  logic clock, nrst, opValid, opWide, vecValid, fpuWrEn, busy, done, undefOp;
  psa_elem_t opElem;
  logic [4:0] opDst, opSrcA, opSrcB, vecDst, vecSrcA, vecSrcB, fpuWrIdx, fpuRdIdx;
  logic [2:0] vecLen;
  logic [63:0] fpuWrData, fpuRdData, rd;
  int miscompares = 0, checks = 0, cycles = 0;
  localparam logic [63:0] A = 64'h80FF_7FFF_FFFF_00FF, B = 64'h8001_0001_0001_0101;
  psa_lane_adder psa_lane_adder_inst (.clock(clock), .nrst(nrst), .opValid(opValid),
    .opWide(opWide), .opElem(opElem), .opDst(opDst), .opSrcA(opSrcA), .opSrcB(opSrcB),
    .vecValid(vecValid), .vectorLengthSetting(vecLen), .vecDst(vecDst), .vecSrcA(vecSrcA),
    .vecSrcB(vecSrcB), .fpuWrEn(fpuWrEn), .fpuWrIdx(fpuWrIdx), .fpuWrData(fpuWrData),
    .fpuRdIdx(fpuRdIdx), .fpuRdData(fpuRdData), .busy(busy), .done(done), .undefOp(undefOp));
  psa_host_model psa_host_model_inst (.clock(clock), .opValid(opValid), .opWide(opWide),
    .opElem(opElem), .opDst(opDst), .opSrcA(opSrcA), .opSrcB(opSrcB), .vecValid(vecValid),
    .vecLen(vecLen), .vecDst(vecDst), .vecSrcA(vecSrcA), .vecSrcB(vecSrcB),
    .fpuWrEn(fpuWrEn), .fpuWrIdx(fpuWrIdx), .fpuWrData(fpuWrData), .fpuRdIdx(fpuRdIdx),
    .fpuRdData(fpuRdData));
  // Lane sum by masking top bits, so no carry can cross a lane edge
  function automatic logic [63:0] laneAdd(logic [63:0] a, b, psa_elem_t e);
    logic [63:0] m;
    m = (e == ELEM_I8) ? 64'h8080_8080_8080_8080 :
        (e == ELEM_I16) ? 64'h8000_8000_8000_8000 : 64'h8000_0000_8000_0000;
    return ((a & ~m) + (b & ~m)) ^ ((a ^ b) & m);
  endfunction
  // 200 MHz clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // Hang guard, far above the 60 or so cycles the run needs
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      miscompares++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Each integer element size on a 64-bit view, carries at lane tops
  task automatic packedNarrow();
    psa_host_model_inst.write(5'h00, A); // Read index already points here
    psa_host_model_inst.write(5'h02, B);
    for (int e = 0; e < 3; e++) begin
      psa_host_model_inst.packedAdd(1'b0, psa_elem_t'(e), 5'(3 + e), 5'h00, 5'h02);
      #1 `CHK("done", 1'b1, done)
      psa_host_model_inst.read(5'(3 + e), rd);
      `CHK("narrow", laneAdd(A, B, psa_elem_t'(e)), rd)
    end
  endtask
  // 128-bit view: Q2 + Q3 into Q5, lower neighbour entry 9 untouched
  task automatic packedWide();
    for (int i = 4; i < 8; i++) psa_host_model_inst.write(5'(i), i[0] ? A : B);
    psa_host_model_inst.packedAdd(1'b1, ELEM_I16, 5'h05, 5'h02, 5'h03);
    psa_host_model_inst.read(5'h0A, rd);
    `CHK("wideLo", laneAdd(B, B, ELEM_I16), rd)
    psa_host_model_inst.read(5'h0B, rd);
    `CHK("wideHi", laneAdd(A, A, ELEM_I16), rd)
    psa_host_model_inst.read(5'h09, rd);
    `CHK("untouched", 64'h0000_0000_0000_0000, rd)
  endtask
  // Four float adds of 1.0 + 1.0 over S0..S3 and S4..S7 into S16..S19
  task automatic vectorRun();
    for (int i = 0; i < 4; i++) psa_host_model_inst.write(5'(i), 64'h3F80_0000_3F80_0000);
    psa_host_model_inst.vector(3'h3, 5'h10, 5'h00, 5'h04);
    repeat (4) begin
      #1 `CHK("busy", 1'b1, busy)
      @(posedge clock);
    end
    #1 `CHK("vecDone", 2'b01, {busy, done})
    psa_host_model_inst.read(5'h08, rd);
    `CHK("vecLo", 64'h4000_0000_4000_0000, rd)
    psa_host_model_inst.read(5'h09, rd);
    `CHK("vecHi", 64'h4000_0000_4000_0000, rd)
    // Packed float lanes on the same 1.0 words, unit present so no undefined flag
    psa_host_model_inst.packedAdd(1'b0, ELEM_F32, 5'h0C, 5'h00, 5'h01);
    #1 `CHK("fltDone", 2'b10, {done, undefOp})
    psa_host_model_inst.read(5'h0C, rd);
    `CHK("fltSum", 64'h4000_0000_4000_0000, rd)
  endtask
  // Reset, then the scenarios
  initial begin
    nrst = 1'b0;
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    psa_host_model_inst.read(5'h00, rd);
    `CHK("reset", 67'h0, {busy, done, undefOp, rd})
    packedNarrow();
    packedWide();
    vectorRun();
    final_report();
  end
endmodule
`undef CHK
`default_nettype wire
